/* File: rtl/reset_brownout_sequencer.sv */
// Chip reset, brownout, wake-up and vector map sequencer
// Behaviour
// R1 - Any of external pin, watchdog, power-on or brownout requests chip reset.
// R2 - Reset holds until request gone, oscillator runs, count elapses, flash ready.
// R3 - After release the processor fetches at address zero from the boot map.
// R4 - All control registers hold defined reset values when reset releases.
// R5 - Supply below upper threshold raises brownout interrupt toward interrupt controller.
// R6 - Warning reaches processor only if enabled outside; always readable in status.
// R7 - Supply below lower threshold forces chip reset and blocks flash alteration.
// R8 - Brownout holds reset while supply falls; power-on detector takes over below.
// R9 - Both brownout thresholds use hysteresis to prevent toggling near crossing.
// R10 - Each external interrupt, edge or level, may be enabled to wake power-down.
// R11 - Software remaps the vector region to boot ROM, SRAM or external memory.
// R12 - After power-down wake, flash access waits for the flash start-up interval.
// R13 - Sleep wake resumes after 4 cycles on RC clock, 4096 on main oscillator.
// R14 - Pin and comparator inputs are synchronised; reset assertion still acts immediately.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
module reset_brownout_sequencer
  import rsq_pkg::*;
#(
  parameter int N_EINT = 32,
  parameter int RESET_WAIT = RESET_WAIT_CYC,
  parameter int SLEEP_MAIN = SLEEP_MAIN_CYC
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ext_reset_n,
  input wire logic wdt_reset,
  input wire logic por_req,
  input wire logic osc_running,
  input wire logic flash_init_done,
  input wire logic bod_warn_below,
  input wire logic bod_warn_above,
  input wire logic bod_rst_below,
  input wire logic bod_rst_above,
  input wire logic [N_EINT-1:0] eint,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DW-1:0] rd_data,
  output logic cpu_reset,
  output logic cpu_run,
  output logic flash_ready,
  output logic flash_init_req,
  output logic flash_lock,
  output logic irc_on,
  output logic bod_irq,
  output logic [1:0] vec_map
);

  typedef struct packed {
    state_t st;
    logic ext_s1;
    logic ext_s2;
    logic [3:0] cause;
    logic [1:0] vec_map;
    logic [N_EINT-1:0] wake_en;
    logic [N_EINT-1:0] wake_lvl;
    logic [N_EINT-1:0] eint_prev;
    logic use_main;
    logic [FCW-1:0] flash_cnt;
    logic flash_ready;
    logic flash_init_req;
    logic flash_lock;
    logic cpu_reset;
    logic cpu_run;
    logic irc_on;
    logic bod_irq;
    logic tstart;
    logic [TW-1:0] tlen;
    logic [DW-1:0] rd_data;
  } seq_state_t;

  seq_state_t q;
  seq_state_t n;
  logic bod_warn_lvl;
  logic bod_rst_lvl;
  logic req_now;
  logic wake_hit;
  logic [3:0] src_vec;

  timer_if tif ();

  function automatic logic reg_hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    reg_hit = (a == ofs);
  endfunction

  // ****************************************
  // Submodules
  // ****************************************
  bod_hyst warn_stage (
    .clk(clk),
    .reset(reset),
    .below(bod_warn_below),
    .above(bod_warn_above),
    .level(bod_warn_lvl)
  );

  bod_hyst rst_stage (
    .clk(clk),
    .reset(reset),
    .below(bod_rst_below),
    .above(bod_rst_above),
    .level(bod_rst_lvl)
  );

  wake_timer timer (
    .clk(clk),
    .reset(reset),
    .tif(tif)
  );

  assign tif.start = q.tstart;
  assign tif.len = q.tlen;

  // ****************************************
  // Request and wake decode
  // ****************************************
  // Raw pin joins the request so assertion needs no synchroniser delay
  assign req_now = !ext_reset_n || !q.ext_s2 || wdt_reset || por_req || bod_rst_lvl; // [R1] [R14]
  assign src_vec = {bod_rst_lvl, por_req, wdt_reset, !q.ext_s2};
  assign wake_hit = |(q.wake_en & ((q.wake_lvl & eint) | (~q.wake_lvl & eint & ~q.eint_prev))); // [R10]

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    n = q;
    n.tstart = 1'b0;
    n.ext_s1 = ext_reset_n; // [R14]
    n.ext_s2 = q.ext_s1;
    n.eint_prev = eint;
    n.bod_irq = bod_warn_lvl; // [R5]
    n.rd_data = '0;
    // Cause flags: a new event in the clearing cycle survives
    if (wr_en && reg_hit(addr, OFS_STATUS))
    begin
      n.cause = q.cause & ~wr_data[CAUSE_LSB +: 4];
    end
    n.cause = n.cause | src_vec;
    // Map, wake and power register writes are ignored while the chip is held in reset; status clears still act
    if (wr_en && !q.cpu_reset)
    begin
      if (reg_hit(addr, OFS_MAP))
      begin
        n.vec_map = wr_data[1:0]; // [R11]
      end
      if (reg_hit(addr, OFS_WAKE_EN))
      begin
        n.wake_en = wr_data[N_EINT-1:0]; // [R10]
      end
      if (reg_hit(addr, OFS_WAKE_LVL))
      begin
        n.wake_lvl = wr_data[N_EINT-1:0];
      end
      if (reg_hit(addr, OFS_PWR))
      begin
        n.use_main = wr_data[PWR_MAIN_BIT];
      end
    end
    if (rd_en)
    begin
      case (addr)
        OFS_MAP: n.rd_data = {30'h0, q.vec_map};
        OFS_PWR: n.rd_data = {27'h0, q.st == S_PDOWN, q.st == S_SLEEP, q.use_main, 2'h0};
        OFS_WAKE_EN: n.rd_data = DW'(q.wake_en);
        OFS_WAKE_LVL: n.rd_data = DW'(q.wake_lvl);
        OFS_STATUS: n.rd_data = {20'h0, q.cause, 5'h0, q.flash_ready, bod_rst_lvl,
          bod_warn_lvl}; // [R6]
        default: n.rd_data = '0;
      endcase
    end
    if (q.flash_cnt != '0)
    begin
      n.flash_cnt = q.flash_cnt - 1'b1;
      if (q.flash_cnt == FCW'(1))
      begin
        n.flash_ready = 1'b1; // [R12]
      end
    end
    case (q.st)
      S_RESET:
      begin
        n.st = S_OSC;
      end
      S_OSC:
      begin
        if (osc_running)
        begin
          n.st = S_COUNT; // [R2]
          n.tstart = 1'b1;
          n.tlen = TW'(RESET_WAIT);
        end
      end
      S_COUNT:
      begin
        if (tif.expired)
        begin
          n.st = S_FLASH;
          n.flash_init_req = 1'b1;
        end
      end
      S_FLASH:
      begin
        if (flash_init_done)
        begin
          n.st = S_RUN; // [R2] [R3]
          n.flash_init_req = 1'b0;
          n.cpu_reset = 1'b0;
          n.cpu_run = 1'b1;
          n.flash_ready = 1'b1;
        end
      end
      S_RUN:
      begin
        if (wr_en && reg_hit(addr, OFS_PWR) && wr_data[PWR_PDOWN_BIT])
        begin
          n.st = S_PDOWN;
          n.cpu_run = 1'b0;
          n.irc_on = 1'b0;
          n.flash_ready = 1'b0;
          n.flash_cnt = '0;
        end
        else if (wr_en && reg_hit(addr, OFS_PWR) && wr_data[PWR_SLEEP_BIT])
        begin
          n.st = S_SLEEP;
          n.cpu_run = 1'b0;
        end
      end
      S_SLEEP:
      begin
        if (wake_hit)
        begin
          n.st = S_WAKE; // [R13]
          n.tstart = 1'b1;
          n.tlen = q.use_main ? TW'(SLEEP_MAIN) : TW'(SLEEP_RC_CYC);
        end
      end
      S_PDOWN:
      begin
        if (wake_hit)
        begin
          n.st = S_WAKE_IRC; // [R10]
          n.irc_on = 1'b1;
          n.tstart = 1'b1;
          n.tlen = TW'(IRC_START_CYC);
        end
      end
      S_WAKE_IRC:
      begin
        // Code from SRAM may resume before the flash is back
        if (tif.expired)
        begin
          n.st = S_WAKE;
          n.tstart = 1'b1;
          n.tlen = TW'(SLEEP_RC_CYC);
          n.flash_cnt = FCW'(FLASH_STARTUP_CYC); // [R12]
        end
      end
      S_WAKE:
      begin
        if (tif.expired)
        begin
          n.st = S_RUN; // [R13]
          n.cpu_run = 1'b1;
        end
      end
      default:
      begin
        n.st = S_RESET;
      end
    endcase
    if (req_now)
    begin
      n.st = S_RESET; // [R1] [R7] [R8]
      n.cpu_reset = 1'b1;
      n.cpu_run = 1'b0;
      n.flash_ready = 1'b0;
      n.flash_init_req = 1'b0;
      n.flash_cnt = '0;
      n.irc_on = 1'b1;
    end
    if (q.cpu_reset)
    begin
      n.vec_map = MAP_RESET; // [R3] [R4]
      n.wake_en = '0;
      n.wake_lvl = '0;
      n.use_main = 1'b0;
    end
    n.flash_lock = n.cpu_reset || bod_rst_lvl; // [R7]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
      q.st <= S_RESET;
      q.ext_s1 <= 1'b1;
      q.ext_s2 <= 1'b1;
      q.cause <= CAUSE_RESET;
      q.vec_map <= MAP_RESET;
      q.cpu_reset <= 1'b1;
      q.flash_lock <= 1'b1;
      q.irc_on <= 1'b1;
    end
    else
    begin
      q <= n;
    end
  end

  assign rd_data = q.rd_data;
  assign cpu_reset = q.cpu_reset;
  assign cpu_run = q.cpu_run;
  assign flash_ready = q.flash_ready;
  assign flash_init_req = q.flash_init_req;
  assign flash_lock = q.flash_lock;
  assign irc_on = q.irc_on;
  assign bod_irq = q.bod_irq;
  assign vec_map = q.vec_map;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_source_forces_reset: assert property ((wdt_reset || por_req) |=> q.cpu_reset) // [R1]
    else $error("reset source did not assert chip reset");
  a_hold_until_osc: assert property ((q.st == S_OSC && !osc_running) |=> q.cpu_reset) // [R2]
    else $error("reset released before oscillator ran");
  a_release_vector: assert property ($fell(q.cpu_reset) |-> // [R3]
    (q.cpu_run && q.vec_map == MAP_BOOT && $past(q.st) == S_FLASH))
    else $error("reset release without boot map or flash init");
  a_regs_defined: assert property ($fell(q.cpu_reset) |-> // [R4]
    (q.wake_en == '0 && q.wake_lvl == '0 && !q.use_main))
    else $error("control registers not at reset value on release");
  a_warn_irq: assert property ($rose(bod_warn_lvl) |=> bod_irq) // [R5]
    else $error("brownout warning did not raise interrupt");
  a_warn_status: assert property ((rd_en && addr == OFS_STATUS) |=> // [R6]
    (rd_data[ST_WARN_BIT] == $past(bod_warn_lvl)))
    else $error("status read does not show brownout warning");
  a_bod_reset_lock: assert property (bod_rst_lvl |=> (q.cpu_reset && q.flash_lock)) // [R7]
    else $error("lower brownout did not reset and lock flash");
  a_por_hold: assert property ((bod_rst_lvl || por_req) |=> (q.st == S_RESET && !q.cpu_run)) // [R8]
    else $error("reset not held during low supply");
  a_pdown_wake: assert property ((q.st == S_PDOWN && wake_hit && !req_now) |=> // [R10]
    (q.st == S_WAKE_IRC && q.irc_on))
    else $error("enabled interrupt did not wake from power-down");
  a_flash_wait: assert property ($rose(q.flash_ready) |-> // [R12]
    ($past(q.flash_cnt) == FCW'(1) || $past(q.st) == S_FLASH))
    else $error("flash ready before start-up interval");
  a_sleep_rc_resume: assert property ((q.st == S_SLEEP && wake_hit && !q.use_main) |-> // [R13]
    ##7 (q.cpu_run || q.cpu_reset))
    else $error("sleep wake on RC clock did not resume after 4 cycles");
  a_pin_fast_assert: assert property ((!ext_reset_n) |=> q.cpu_reset) // [R14]
    else $error("external reset not honoured at once");

  c_reset_release: cover property ($fell(q.cpu_reset));
  c_sleep_wake: cover property (q.st == S_WAKE ##1 q.st == S_RUN);
  c_flash_back: cover property ($rose(q.flash_ready) && q.st == S_RUN);
  c_bod_irq: cover property ($rose(bod_irq));

endmodule

/* File: rtl/rsq_pkg.sv */
// Shared constants, register map and state encoding of the reset and brownout sequencer
package rsq_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int FLASH_STARTUP_NS = 100000;
  localparam int FLASH_STARTUP_CYC = (FLASH_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRC_START_NS = 60000;
  localparam int IRC_START_CYC = (IRC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_RC_CYC = 4;
  localparam int SLEEP_MAIN_CYC = 4096;
  localparam int RESET_WAIT_CYC = 256;
  localparam int TW = 16;
  localparam int FCW = 12;

  // ****************************************
  // Register map
  // ****************************************
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [7:0] OFS_MAP = 8'h00;
  localparam logic [7:0] OFS_PWR = 8'h04;
  localparam logic [7:0] OFS_WAKE_EN = 8'h08;
  localparam logic [7:0] OFS_WAKE_LVL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  localparam int PWR_SLEEP_BIT = 0;
  localparam int PWR_PDOWN_BIT = 1;
  localparam int PWR_MAIN_BIT = 2;
  localparam int PWR_IN_SLEEP_BIT = 3;
  localparam int PWR_IN_PDOWN_BIT = 4;
  localparam int ST_WARN_BIT = 0;
  localparam int ST_BODRST_BIT = 1;
  localparam int ST_FLASH_BIT = 2;
  localparam int CAUSE_LSB = 8;

  // ****************************************
  // Vector map and reset values
  // ****************************************
  localparam logic [1:0] MAP_BOOT = 2'h0;
  localparam logic [1:0] MAP_SRAM = 2'h1;
  localparam logic [1:0] MAP_EXT = 2'h2;
  localparam logic [1:0] MAP_RESET = MAP_BOOT;
  localparam logic [3:0] CAUSE_RESET = 4'h0;

  typedef enum logic [3:0] {
    S_RESET, S_OSC, S_COUNT, S_FLASH, S_RUN, S_SLEEP, S_PDOWN, S_WAKE_IRC, S_WAKE
  } state_t;

endpackage

/* File: rtl/timer_if.sv */
// Start and expiry handshake between the sequencer and its wake-up timer
`timescale 1ns/100ps
interface timer_if;
  import rsq_pkg::*;
  logic start;
  logic [TW-1:0] len;
  logic expired;
  modport seq (output start, output len, input expired);
  modport timer (input start, input len, output expired);
endinterface

/* File: rtl/wake_timer.sv */
// Down counter shared by reset, sleep and power-down wake-up waits
`timescale 1ns/100ps
module wake_timer
  import rsq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  timer_if.timer tif
);

  typedef struct packed {
    logic [TW-1:0] cnt;
  } tstate_t;

  tstate_t q;
  tstate_t n;

  // ****************************************
  // Counter
  // ****************************************
  always_comb
  begin
    n = q;
    if (tif.start)
    begin
      n.cnt = tif.len;
    end
    else if (q.cnt != '0)
    begin
      n.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  // Start masks expiry so a stale zero is never seen as done
  assign tif.expired = (q.cnt == '0) && !tif.start;

endmodule

/* File: rtl/bod_hyst.sv */
// Synchronised brownout comparator pair with set and clear thresholds
`timescale 1ns/100ps
module bod_hyst
  import rsq_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic below,
  input wire logic above,
  output logic level
);

  typedef struct packed {
    logic s1b;
    logic s2b;
    logic s1a;
    logic s2a;
    logic lvl;
  } hstate_t;

  hstate_t q;
  hstate_t n;

  // ****************************************
  // Synchroniser and hysteresis
  // ****************************************
  always_comb
  begin
    n = q;
    n.s1b = below; // [R14]
    n.s2b = q.s1b;
    n.s1a = above;
    n.s2a = q.s1a;
    // Clears only above the upper band, so noise at the trip point cannot chatter
    if (q.s2b)
    begin
      n.lvl = 1'b1; // [R9]
    end
    else if (q.s2a)
    begin
      n.lvl = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  assign level = q.lvl;

  a_hyst_hold: assert property (@(posedge clk) disable iff (reset) // [R9]
    (q.lvl && !q.s2a) |=> q.lvl)
    else $error("brownout flag dropped inside hysteresis band");

endmodule

/* File: sim/supply_model.sv */
// Supply rail model: brownout comparators, power-on detector and interrupt enable gate
`timescale 1ns/100ps
module supply_model
#(
  parameter logic [15:0] HYST_MV = 16'h0032
)
(
  input wire logic [15:0] mv,
  input wire logic irq_en,
  input wire logic bod_irq,
  output logic warn_below,
  output logic warn_above,
  output logic rst_below,
  output logic rst_above,
  output logic por_req,
  output logic cpu_irq
);
  // ****************************************
  // Comparators
  // ****************************************
  // Upper stage set point and its release point one hysteresis step higher
  assign warn_below = mv < 16'h0b86;
  assign warn_above = mv >= 16'h0b86 + HYST_MV;
  // Lower stage keeps reset asked for all the way down to the power-on level
  assign rst_below = mv < 16'h0a5a;
  assign rst_above = mv >= 16'h0a5a + HYST_MV;
  assign por_req = mv < 16'h03e8;
  // Interrupt controller only passes the warning when software enabled it
  assign cpu_irq = bod_irq & irq_en;
endmodule

/* File: sim/reset_brownout_sequencer_tb.sv */
// Self-checking bench for the reset and brownout sequencer
`timescale 1ns/100ps
module reset_brownout_sequencer_tb;
  import rsq_pkg::*;
  // Short counts keep the run brief; expectations follow them
  localparam int RW = 4;
  localparam int SM = 16;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ext_reset_n = 1'b1;
  logic wdt_reset = 1'b0;
  logic osc_running = 1'b0;
  logic flash_init_done = 1'b0;
  logic [31:0] eint = '0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic irq_en = 1'b0;
  logic [15:0] mv = 16'h0ce4;
  logic [DW-1:0] rd_data, q;
  logic cpu_reset, cpu_run, flash_ready, flash_init_req, flash_lock, irc_on, bod_irq;
  logic por_req, warn_below, warn_above, rst_below, rst_above, cpu_irq;
  logic [1:0] vec_map;
  int n_mismatch = 0;
  int n_compared = 0;
  int cnt;

  always #25 clk = ~clk;

  reset_brownout_sequencer #(.N_EINT(32), .RESET_WAIT(RW), .SLEEP_MAIN(SM))
  u_reset_brownout_sequencer (.clk(clk), .reset(reset), .ext_reset_n(ext_reset_n),
    .wdt_reset(wdt_reset), .por_req(por_req), .osc_running(osc_running),
    .flash_init_done(flash_init_done), .bod_warn_below(warn_below),
    .bod_warn_above(warn_above), .bod_rst_below(rst_below), .bod_rst_above(rst_above),
    .eint(eint), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .cpu_reset(cpu_reset), .cpu_run(cpu_run),
    .flash_ready(flash_ready), .flash_init_req(flash_init_req), .flash_lock(flash_lock),
    .irc_on(irc_on), .bod_irq(bod_irq), .vec_map(vec_map));

  supply_model u_supply_model (.mv(mv), .irq_en(irq_en), .bod_irq(bod_irq),
    .warn_below(warn_below), .warn_above(warn_above), .rst_below(rst_below),
    .rst_above(rst_above), .por_req(por_req), .cpu_irq(cpu_irq));

  // ****************************************
  // Bus and check tasks
  // ****************************************
  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // Counts edges until the chosen output goes high, bounded so a hang cannot stall us
  task automatic wait_on(input int sel, input int lim);
    cnt = 0;
    while (cnt < lim && (sel == 0 ? cpu_run : sel == 1 ? flash_init_req : flash_ready) !== 1'b1)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    // A limit that runs out is a failure in its own right
    if ((sel == 0 ? cpu_run : sel == 1 ? flash_init_req : flash_ready) !== 1'b1)
      n_mismatch++;
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (19) @(posedge clk);
    #1;
    chk(32'({cpu_reset, flash_lock, irc_on, cpu_run, flash_ready, bod_irq, vec_map}), 32'he0);
    @(posedge clk);
    reset <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    chk(cpu_reset, 1'b1);
    @(posedge clk);
    osc_running <= 1'b1;
    #1;
    wait_on(1, 60);
    chk(32'(cnt), 32'(RW + 3));
    repeat (10) @(posedge clk);
    #1;
    chk(cpu_reset, 1'b1);
    @(posedge clk);
    flash_init_done <= 1'b1;
    #1;
    wait_on(0, 10);
    chk({cpu_reset, flash_ready, vec_map}, {2'h1, MAP_BOOT});
    for (int i = 0; i < 4; i++)
    begin
      rd(8'(4 * i), q);
      chk(q, 32'h0);
    end
    rd(OFS_STATUS, q);
    chk(q, 32'h4);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_MAP, 32'({MAP_BOOT, MAP_EXT, MAP_SRAM} >> (2 * i)) & 32'h3);
      rd(OFS_MAP, q);
      chk({q[1:0], vec_map}, {2{2'({MAP_BOOT, MAP_EXT, MAP_SRAM} >> (2 * i))}});
    end
    rd(8'hfc, q);
    chk(q, 32'h0);
    // Warning stage, then a rise that stays inside the hysteresis band
    @(posedge clk);
    mv <= 16'h0b54;
    repeat (6) @(posedge clk);
    #1;
    chk({bod_irq, cpu_irq}, 2'h2);
    rd(OFS_STATUS, q);
    chk(q & 32'h1, 32'h1);
    @(posedge clk);
    irq_en <= 1'b1;
    mv <= 16'h0b90;
    repeat (10) @(posedge clk);
    #1;
    chk({bod_irq, cpu_irq}, 2'h3);
    @(posedge clk);
    mv <= 16'h0ce4;
    repeat (6) @(posedge clk);
    #1;
    chk(bod_irq, 1'b0);
    // Sleep on the RC clock, then on the main oscillator
    wr(OFS_WAKE_EN, 32'h1);
    wr(OFS_WAKE_LVL, 32'h0);
    for (int m = 0; m < 2; m++)
    begin
      wr(OFS_PWR, m ? 32'h5 : 32'h1);
      @(posedge clk);
      eint <= 32'h4;
      repeat (10) @(posedge clk);
      #1;
      chk(cpu_run, 1'b0);
      rd(OFS_PWR, q);
      chk(q, m ? 32'hc : 32'h8);
      @(posedge clk);
      eint <= 32'h5;
      #1;
      wait_on(0, 100);
      chk(32'(cnt), m ? 32'(SM + 3) : 32'(SLEEP_RC_CYC + 3));
      @(posedge clk);
      eint <= '0;
    end
    // Power-down with a level wake; flash stays closed for its start-up interval
    wr(OFS_WAKE_EN, 32'h2);
    wr(OFS_WAKE_LVL, 32'h2);
    wr(OFS_PWR, 32'h2);
    repeat (3) @(posedge clk);
    #1;
    chk({irc_on, cpu_run, flash_ready}, 3'h0);
    @(posedge clk);
    eint <= 32'h2;
    #1;
    wait_on(0, IRC_START_CYC + 20);
    chk(32'(cnt), 32'(IRC_START_CYC + SLEEP_RC_CYC + 5));
    chk({cpu_run, flash_ready}, 2'h2);
    wait_on(2, FLASH_STARTUP_CYC + 20);
    chk(32'(cnt), 32'(FLASH_STARTUP_CYC - SLEEP_RC_CYC - 2));
    @(posedge clk);
    eint <= '0;
    // External pin, then watchdog
    for (int k = 0; k < 2; k++)
    begin
      wr(OFS_MAP, 32'(MAP_SRAM));
      wr(OFS_STATUS, 32'hf00);
      @(posedge clk);
      ext_reset_n <= (k != 0);
      wdt_reset <= (k == 1);
      @(posedge clk);
      #1;
      chk({cpu_reset, flash_lock}, 2'h3);
      repeat (5) @(posedge clk);
      ext_reset_n <= 1'b1;
      wdt_reset <= 1'b0;
      #1;
      wait_on(0, 60);
      chk({cpu_run, vec_map}, {1'b1, MAP_BOOT});
      rd(OFS_STATUS, q);
      chk(q & 32'hf00, 32'h100 << k);
    end
    // Lower stage, fall to power-on level, recover through the hysteresis band
    wr(OFS_STATUS, 32'hf00);
    @(posedge clk);
    mv <= 16'h0a28;
    repeat (6) @(posedge clk);
    #1;
    chk({cpu_reset, flash_lock}, 2'h3);
    @(posedge clk);
    mv <= 16'h0384;
    repeat (6) @(posedge clk);
    mv <= 16'h0a64;
    repeat (20) @(posedge clk);
    #1;
    chk(cpu_reset, 1'b1);
    @(posedge clk);
    mv <= 16'h0ce4;
    wait_on(0, 80);
    chk(cpu_run, 1'b1);
    rd(OFS_STATUS, q);
    chk(q & 32'hf00, 32'hc00);
    give_verdict();
  end
endmodule
